/* dv/slb_panel_model.sv */
// passive panel model: pixels between common line 0 and each segment-only line
`timescale 1ns/1ps
`default_nettype none
module slb_panel_model (
    input wire logic [2*slb_pkg::NUM_PIN-1:0] line_level,
    input wire logic [slb_pkg::NUM_PIN-1:0] line_lcd_active,
    output logic [slb_pkg::NUM_SEG-1:0] lit
);
    import slb_pkg::*;
    // only a full-supply difference lights a pixel under 1/3 bias
    always_comb begin
        for (int j = 0; j < NUM_SEG; j++) begin
            lit[j] = line_lcd_active[0] && line_lcd_active[j+NUM_COM] &&
                ((line_level[1:0] == 2'h3 && line_level[2*(j+NUM_COM) +: 2] == 2'h0) ||
                (line_level[1:0] == 2'h0 && line_level[2*(j+NUM_COM) +: 2] == 2'h3));
        end
    end
endmodule : slb_panel_model
`default_nettype wire

/* dv/slb_top_properties.sv */
// checker: port-level timing and level relations of the lcd bias driver
`timescale 1ns/1ps
`default_nettype none
module slb_top_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [slb_pkg::NUM_PIN-1:0] gpio_dir_out,
    input wire logic [2*slb_pkg::NUM_PIN-1:0] line_level,
    input wire logic [slb_pkg::NUM_PIN-1:0] line_lcd_active,
    input wire logic [slb_pkg::NUM_PIN-1:0] pin_out,
    input wire logic [slb_pkg::NUM_PIN-1:0] pin_oe,
    input wire logic [1:0] bias_current_sel
);
    import slb_pkg::*;
    logic [NUM_PIN-1:0] lvl_nz;
    logic [NUM_SEG-1:0] seg_b0;
    logic [NUM_SEG-1:0] seg_act;
    // bit 0 of a segment-only level carries the frame, so all active ones must agree
    always_comb begin
        for (int i = 0; i < NUM_PIN; i++) lvl_nz[i] = |line_level[2*i +: 2];
        for (int j = 0; j < NUM_SEG; j++) seg_b0[j] = line_level[2*(j+NUM_COM)];
        seg_act = line_lcd_active[NUM_PIN-1:NUM_COM];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_resp;
        ##2 s_axi_bvalid;
    endsequence
    chk_idle_ground: assert property ((lvl_nz & ~line_lcd_active) == '0)
        else $error("level driven on a pin not in lcd use");
    chk_lcd_no_drive: assert property ((line_lcd_active & (pin_oe | pin_out)) == '0)
        else $error("gpio drive on a pin owned by lcd");
    chk_gpio_dir: assert property (!$past(sys_rst) |->
        pin_oe == ($past(gpio_dir_out) & ~line_lcd_active)) else $error("pin_oe wrong");
    chk_frame_agree: assert property (((seg_b0 & seg_act) == '0) ||
        ((seg_b0 | ~seg_act) == '1)) else $error("segment lines disagree on frame");
    chk_bias_write: assert property ($changed(bias_current_sel) |-> $rose(s_axi_bvalid))
        else $error("bias select moved without a write");
    chk_level_write: assert property ($changed(line_level) || $changed(line_lcd_active)
        |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("level moved off write");
    chk_write_resp: assert property (wr_take |-> wr_resp)
        else $error("write response late");
    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : slb_top_properties
bind slb_top slb_top_properties slb_top_properties_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .gpio_dir_out(gpio_dir_out), .line_level(line_level),
    .line_lcd_active(line_lcd_active), .pin_out(pin_out), .pin_oe(pin_oe),
    .bias_current_sel(bias_current_sel));
`default_nettype wire

/* dv/tb_top.sv */
// testbench: axi register access, random line programming, scoreboard and panel check
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import slb_pkg::*;
    typedef struct {logic rd; logic [31:0] data; logic [1:0] resp;} slb_exp_t;
    logic core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, c0, c1;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, bias;
    logic [NUM_PIN-1:0] dir, gout, act, pout, poe, fn, dt, xa;
    logic [2*NUM_PIN-1:0] lvl, xl;
    logic [NUM_SEG-1:0] lit, xt;
    slb_exp_t exq[$];
    slb_exp_t e;
    int error_cnt, checks, cyc;
    slb_top slb_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .gpio_dir_out(dir), .gpio_out(gout), .line_level(lvl), .line_lcd_active(act),
        .pin_out(pout), .pin_oe(poe), .bias_current_sel(bias));
    slb_panel_model slb_panel_model_inst (.line_level(lvl), .line_lcd_active(act), .lit(lit));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // frame 0 common and frame 1 segment share the full/third pair
    function automatic logic [1:0] lv(input logic f, input logic seg, input logic d);
        return (seg ^ f) ? (d ? 2'h0 : 2'h2) : (d ? 2'h3 : 2'h1);
    endfunction : lv
    task automatic cmp(input string nm, input logic [89:0] ex, input logic [89:0] got);
        checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // random ready delays exercise the slave's hold of bvalid and rvalid
    task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        exq.push_back('{rd, rd ? d : 32'h0, r});
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= !rd;
        wvalid <= !rd;
        arvalid <= rd;
        bready <= xs() > 32'h7FFFFFFF;
        rready <= xs() > 32'h7FFFFFFF;
        forever begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if ((bvalid && bready) || (rvalid && rready)) break;
            if (bvalid) bready <= 1'b1;
            if (rvalid) rready <= 1'b1;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = exq.pop_front();
            cmp("resp", 90'(e.resp), 90'(rvalid ? rresp : bresp));
            if (e.rd) cmp("rdata", 90'(e.data), 90'(rdata));
        end
        // timeout is the last step so nothing runs after the closing report
        if (cyc > 40000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {dir, gout, error_cnt, checks, cyc} = '0;
        wstrb = 4'hF;
        seed = 32'd9135;
        sys_rst = 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        cmp("line_level", '0, lvl);
        for (int a = 0; a < 28; a += 4) bus(1'b1, 12'(a), 32'h0, RESP_OKAY);
        bus(1'b1, 12'h01C, 32'h0, RESP_SLVERR);
        bus(1'b0, OFF_STATUS, 32'h1, RESP_SLVERR);
        for (int k = 0; k < 16; k++) begin
            c0 = xs();
            c1 = xs();
            c0[4] = k % 4 != 0;
            c0[6:5] = 2'(k);
            c0[7] = k[2];
            fn = {13'(xs()), xs()};
            dt = {13'(xs()), xs()};
            dir <= {13'(xs()), xs()};
            gout <= {13'(xs()), xs()};
            bus(1'b0, OFF_PIN_FUNC_LO, fn[31:0], RESP_OKAY);
            bus(1'b0, OFF_PIN_FUNC_HI, 32'(fn[44:32]), RESP_OKAY);
            bus(1'b0, OFF_IO_DATA_LO, dt[31:0], RESP_OKAY);
            bus(1'b0, OFF_IO_DATA_HI, 32'(dt[44:32]), RESP_OKAY);
            bus(1'b0, OFF_LINE_ROLE, c1, RESP_OKAY);
            bus(1'b0, OFF_FRAME_BIAS, c0, RESP_OKAY);
            for (int i = 0; i < NUM_PIN; i++) begin
                xa[i] = c0[4] && fn[i];
                xl[2*i +: 2] = xa[i] ? lv(c0[7], i >= NUM_COM || c1[i % NUM_COM], dt[i]) : 2'h0;
            end
            for (int j = 0; j < NUM_SEG; j++) begin
                xt[j] = xa[0] && xa[j+NUM_COM] && xl[0] == xl[1] &&
                    (xl[1:0] ^ xl[2*(j+NUM_COM) +: 2]) == 2'h3;
            end
            cmp("line_level", xl, lvl);
            cmp("lcd_active", 90'(xa), 90'(act));
            cmp("pin_oe", 90'(dir & ~xa), 90'(poe));
            cmp("pin_out", 90'(gout & ~xa), 90'(pout));
            cmp("lit", 90'(xt), 90'(lit));
            cmp("bias", 90'(c0[6:5]), 90'(bias));
            bus(1'b1, OFF_FRAME_BIAS, c0 & 32'hF0, RESP_OKAY);
            bus(1'b1, OFF_LINE_ROLE, c1 & 32'h3F, RESP_OKAY);
            bus(1'b1, OFF_STATUS, 32'(c0[4]), RESP_OKAY);
        end
        close_out();
    end
endmodule : tb_top
`default_nettype wire

/* pkg/slb_pkg.sv */
// package: register map, field positions, reset values and level codes of the lcd bias driver
package slb_pkg;
    localparam int unsigned NUM_COM = 6;
    localparam int unsigned NUM_SEG = 39;
    localparam int unsigned NUM_PIN = NUM_COM + NUM_SEG;
    localparam logic [11:0] OFF_FRAME_BIAS = 12'h000;
    localparam logic [11:0] OFF_LINE_ROLE = 12'h004;
    localparam logic [11:0] OFF_PIN_FUNC_LO = 12'h008;
    localparam logic [11:0] OFF_PIN_FUNC_HI = 12'h00C;
    localparam logic [11:0] OFF_IO_DATA_LO = 12'h010;
    localparam logic [11:0] OFF_IO_DATA_HI = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;
    localparam int unsigned FRAME_BIT = 7;
    localparam int unsigned BIAS_HI_BIT = 6;
    localparam int unsigned BIAS_LO_BIT = 5;
    localparam int unsigned ENABLE_BIT = 4;
    localparam logic [7:0] FRAME_BIAS_MASK = 8'hF0;
    localparam logic [7:0] LINE_ROLE_MASK = 8'h3F;
    localparam logic [7:0] FRAME_BIAS_RST = 8'h00;
    localparam logic [7:0] LINE_ROLE_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        SLB_LVL_GND = 2'h0,
        SLB_LVL_THIRD = 2'h1,
        SLB_LVL_TWO_THIRDS = 2'h2,
        SLB_LVL_FULL = 2'h3
    } slb_level_t;
endpackage : slb_pkg

/* src/slb_axil_slave.sv */
// axi4-lite slave front end: one write and one read at a time, byte strobes
`timescale 1ns/1ps
`default_nettype none
module slb_axil_slave (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_pulse,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    import slb_pkg::*;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // address and data may land in either order; both held until the response
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_pulse = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_addr = awaddr_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wr_pulse) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_pulse) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : slb_axil_slave
`default_nettype wire

/* src/slb_level_sel.sv */
// one line's output level chooser from frame, role and data bit
`timescale 1ns/1ps
`default_nettype none
module slb_level_sel (
    input wire logic drive_on,
    input wire logic frame,
    input wire logic is_segment,
    input wire logic data_bit,
    output slb_pkg::slb_level_t level
);
    import slb_pkg::*;
    always_comb begin
        if (!drive_on) begin
            level = SLB_LVL_GND;
        end else if (!frame) begin
            if (!is_segment) begin
                level = data_bit ? SLB_LVL_FULL : SLB_LVL_THIRD; // [RL7] [RL13]
            end else begin
                level = data_bit ? SLB_LVL_GND : SLB_LVL_TWO_THIRDS; // [RL7] [RL13]
            end
        end else begin
            if (!is_segment) begin
                level = data_bit ? SLB_LVL_GND : SLB_LVL_TWO_THIRDS; // [RL8] [RL13]
            end else begin
                level = data_bit ? SLB_LVL_FULL : SLB_LVL_THIRD; // [RL8] [RL13]
            end
        end
    end
endmodule : slb_level_sel
`default_nettype wire

/* src/slb_top.sv */
// lcd bias driver top: control registers, pin function map and per-line levels
// Functional notes
// RL1: six common lines and thirty-nine segment lines exist, each shared with an i/o pin.
// RL2: bit 7 of the frame/bias register picks frame 0 when clear and frame 1 when set.
// RL3: bits 6..5 pick bias current 8.3, 16.7, 50 or 100 microamps in that order.
// RL4: with the drive enable (bit 4) clear every common and segment output sits at ground.
// RL5: a pin is an lcd line only when drive enable is set and its own pin function selects lcd.
// RL6: bits 5..0 of the role register make line n common when 0 and segment when 1.
// RL7: in frame 0 common gives full or one third, segment gives ground or two thirds.
// RL8: in frame 1 common gives ground or two thirds, segment gives full or one third.
// RL9: each line's level comes from the frame bit together with that pin's i/o data bit.
// RL10: lcd drive works without the pin's port direction being set to output.
// RL11: software sets enable and pin selections before relying on lcd pin functions.
// RL12: unimplemented bits (3..0 of frame/bias, 7..6 of role) read as zero.
// RL13: a data bit of 1 selects the frame's full-swing level, 0 its bias level.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module slb_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [slb_pkg::NUM_PIN-1:0] gpio_dir_out,
    input wire logic [slb_pkg::NUM_PIN-1:0] gpio_out,
    output logic [2*slb_pkg::NUM_PIN-1:0] line_level,
    output logic [slb_pkg::NUM_PIN-1:0] line_lcd_active,
    output logic [slb_pkg::NUM_PIN-1:0] pin_out,
    output logic [slb_pkg::NUM_PIN-1:0] pin_oe,
    output logic [1:0] bias_current_sel
);
    import slb_pkg::*;

    logic [7:0] lcd_frame_bias_control_r;
    logic [7:0] lcd_line_role_select_r;
    logic [NUM_PIN-1:0] pin_func_lcd_r;
    logic [NUM_PIN-1:0] io_data_r;
    logic wr_pulse;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic frame_sel;
    logic display_drive_enable;
    logic [NUM_PIN-1:0] lcd_sel;
    slb_level_t level_w [NUM_PIN];
    logic [31:0] pin_func_hi_nxt;
    logic [31:0] io_data_hi_nxt;

    // strobe-merge of a 32-bit word into a stored word
    function automatic logic [31:0] merge_word(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_word

    function automatic logic addr_known(input logic [11:0] a);
        return (a == OFF_FRAME_BIAS) || (a == OFF_LINE_ROLE) || (a == OFF_PIN_FUNC_LO) ||
               (a == OFF_PIN_FUNC_HI) || (a == OFF_IO_DATA_LO) || (a == OFF_IO_DATA_HI) ||
               (a == OFF_STATUS);
    endfunction : addr_known

    slb_axil_slave u_bus (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // status register is read-only, so a write to it is an error
    assign wr_ok = addr_known(wr_addr) && (wr_addr != OFF_STATUS);
    assign rd_ok = addr_known(rd_addr);
    // upper words are merged at full width, then only the 13 live bits are kept
    assign pin_func_hi_nxt = merge_word({19'h0, pin_func_lcd_r[NUM_PIN-1:32]}, wr_data, wr_strb);
    assign io_data_hi_nxt = merge_word({19'h0, io_data_r[NUM_PIN-1:32]}, wr_data, wr_strb);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lcd_frame_bias_control_r <= FRAME_BIAS_RST;
        end else if (wr_pulse && wr_addr == OFF_FRAME_BIAS && wr_strb[0]) begin
            lcd_frame_bias_control_r <= wr_data[7:0] & FRAME_BIAS_MASK; // [RL12]
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lcd_line_role_select_r <= LINE_ROLE_RST;
        end else if (wr_pulse && wr_addr == OFF_LINE_ROLE && wr_strb[0]) begin
            lcd_line_role_select_r <= wr_data[7:0] & LINE_ROLE_MASK; // [RL12]
        end
    end

    // pin function and i/o data stand in for the port logic that shares the pins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_func_lcd_r <= '0;
        end else if (wr_pulse && wr_addr == OFF_PIN_FUNC_LO) begin
            pin_func_lcd_r[31:0] <= merge_word(pin_func_lcd_r[31:0], wr_data, wr_strb);
        end else if (wr_pulse && wr_addr == OFF_PIN_FUNC_HI) begin
            pin_func_lcd_r[NUM_PIN-1:32] <= pin_func_hi_nxt[NUM_PIN-33:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            io_data_r <= '0;
        end else if (wr_pulse && wr_addr == OFF_IO_DATA_LO) begin
            io_data_r[31:0] <= merge_word(io_data_r[31:0], wr_data, wr_strb);
        end else if (wr_pulse && wr_addr == OFF_IO_DATA_HI) begin
            io_data_r[NUM_PIN-1:32] <= io_data_hi_nxt[NUM_PIN-33:0];
        end
    end

    assign frame_sel = lcd_frame_bias_control_r[FRAME_BIT]; // [RL2]
    assign display_drive_enable = lcd_frame_bias_control_r[ENABLE_BIT];
    assign bias_current_sel = lcd_frame_bias_control_r[BIAS_HI_BIT:BIAS_LO_BIT]; // [RL3]
    // lcd ownership ignores the direction bits entirely
    assign lcd_sel = pin_func_lcd_r & {NUM_PIN{display_drive_enable}}; // [RL5] [RL10]

    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            OFF_FRAME_BIAS: rd_data = {24'h0, lcd_frame_bias_control_r}; // [RL12]
            OFF_LINE_ROLE: rd_data = {24'h0, lcd_line_role_select_r}; // [RL12]
            OFF_PIN_FUNC_LO: rd_data = pin_func_lcd_r[31:0];
            OFF_PIN_FUNC_HI: rd_data = {19'h0, pin_func_lcd_r[NUM_PIN-1:32]};
            OFF_IO_DATA_LO: rd_data = io_data_r[31:0];
            OFF_IO_DATA_HI: rd_data = {19'h0, io_data_r[NUM_PIN-1:32]};
            OFF_STATUS: rd_data = {31'h0, display_drive_enable};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // pins 0..5 carry common or segment by role bits; pins 6..44 are segment only
    for (genvar i = 0; i < NUM_PIN; i++) begin : g_line // [RL1]
        logic is_seg;
        if (i < NUM_COM) begin : g_shared
            assign is_seg = lcd_line_role_select_r[i]; // [RL6]
        end else begin : g_seg
            assign is_seg = 1'b1;
        end
        slb_level_sel u_lvl (
            .drive_on(display_drive_enable), // [RL4]
            .frame(frame_sel),
            .is_segment(is_seg),
            .data_bit(io_data_r[i]), // [RL9]
            .level(level_w[i])
        );
    end

    // level, ownership and gpio mux registered so outputs come from flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_level <= '0;
            line_lcd_active <= '0;
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            for (int i = 0; i < NUM_PIN; i++) begin
                // lcd pins not selected still read ground: drive is off there
                line_level[2*i +: 2] <= lcd_sel[i] ? level_w[i] : SLB_LVL_GND; // [RL4] [RL5]
                line_lcd_active[i] <= lcd_sel[i];
                pin_out[i] <= lcd_sel[i] ? 1'b0 : gpio_out[i];
                pin_oe[i] <= lcd_sel[i] ? 1'b0 : gpio_dir_out[i]; // [RL10]
            end
        end
    end
endmodule : slb_top
`default_nettype wire
